/* File: logic/hidp_pkg.sv */
package hidp_pkg;
  // ----------------------------------------------------------------
  // device register map (processor side)
  // ----------------------------------------------------------------
  localparam logic [13:0] HIDP_CTRL_ADDR = 14'h3FE0;
  localparam logic [13:0] HIDP_TIMING_ADDR = 14'h3FE7;
  localparam int HIDP_TIMING_SHORT_BIT = 14;
  localparam logic [15:0] HIDP_CTRL_RESET = 16'h0000;
  localparam logic [15:0] HIDP_TIMING_RESET = 16'h0000;
  // ----------------------------------------------------------------
  // control word fields
  // ----------------------------------------------------------------
  localparam int HIDP_OVL_FLAG_BIT = 15;
  localparam int HIDP_MEM_TYPE_BIT = 14;
  localparam int HIDP_ADDR_W = 14;
  localparam int HIDP_OVL_W = 8;
  localparam int HIDP_BUS_W = 16;
  localparam int HIDP_PM_W = 24;
  // ----------------------------------------------------------------
  // boot straps and memory sizes
  // ----------------------------------------------------------------
  localparam logic [2:0] HIDP_BOOT_PORT_MODE = 3'h5;
  localparam int HIDP_PM_DEPTH = 64;
  localparam int HIDP_DM_DEPTH = 64;
  localparam int HIDP_FIFO_DEPTH = 4;
  // ----------------------------------------------------------------
  // host controller register map
  // ----------------------------------------------------------------
  localparam logic [3:0] HIDP_HC_CMD = 4'h0;
  localparam logic [3:0] HIDP_HC_WDATA = 4'h1;
  localparam logic [3:0] HIDP_HC_RDATA = 4'h2;
  localparam logic [3:0] HIDP_HC_STATUS = 4'h3;
  localparam logic [1:0] HIDP_OP_LATCH = 2'h0;
  localparam logic [1:0] HIDP_OP_WRITE = 2'h1;
  localparam logic [1:0] HIDP_OP_READ = 2'h2;
  localparam int HIDP_CMD_W = HIDP_BUS_W + 2;

  typedef enum logic [3:0] {
    HIDP_DS_IDLE = 4'b0001,
    HIDP_DS_SYNC = 4'b0010,
    HIDP_DS_MEM = 4'b0100,
    HIDP_DS_DONE = 4'b1000
  } hidp_dstate_t;

  typedef enum logic [3:0] {
    HIDP_HS_IDLE = 4'b0001,
    HIDP_HS_WAITACK = 4'b0010,
    HIDP_HS_STROBE = 4'b0100,
    HIDP_HS_END = 4'b1000
  } hidp_hstate_t;
endpackage : hidp_pkg

/* File: logic/hidp_if.sv */
`timescale 1ns/100ps
interface hidp_if;
  logic port_select_n;
  logic address_latch_strobe;
  logic host_read_strobe_n;
  logic host_write_strobe_n;
  logic port_ack;
  logic [15:0] bus_host_out;
  logic bus_host_oe;
  logic [15:0] bus_dev_out;
  logic bus_dev_oe;
  logic [15:0] shared_port_bus;

  // ----------------------------------------------------------------
  // resolved shared bus
  // ----------------------------------------------------------------
  assign shared_port_bus = bus_host_oe ? bus_host_out : (bus_dev_oe ? bus_dev_out : 16'h0000);

  modport device (
    input port_select_n, address_latch_strobe, host_read_strobe_n, host_write_strobe_n,
    input shared_port_bus,
    output port_ack, bus_dev_out, bus_dev_oe
  );
  modport host (
    output port_select_n, address_latch_strobe, host_read_strobe_n, host_write_strobe_n,
    output bus_host_out, bus_host_oe,
    input port_ack, shared_port_bus
  );
endinterface : hidp_if

/* File: logic/hidp_fifo.sv */
`timescale 1ns/100ps
module hidp_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : hidp_fifo

/* File: logic/hidp_device.sv */
`timescale 1ns/100ps
module hidp_device
  import hidp_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // host port
  hidp_if.device port,
  // processor register access
  input wire logic [13:0] cpu_addr,
  input wire logic [15:0] cpu_wdata,
  input wire logic cpu_write,
  input wire logic cpu_read,
  output logic [15:0] cpu_rdata,
  // boot straps and run control
  input wire logic [2:0] boot_mode,
  output logic core_run,
  output logic [7:0] overlay_select,
  output logic short_read_mode
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  hidp_dstate_t state;
  logic [15:0] bus_q;
  logic sel_q;
  logic als_q;
  logic rd_q;
  logic wr_q;
  logic [HIDP_ADDR_W-1:0] start_address_latch;
  logic mem_is_dm;
  logic half_sel;
  logic [15:0] pm_low;
  logic op_write;
  logic [23:0] program_memory [HIDP_PM_DEPTH];
  logic [15:0] data_memory [HIDP_DM_DEPTH];
  logic [15:0] timing_reg;
  logic boot_port;
  logic strap_taken;
  logic [5:0] idx;
  logic latch_event;
  logic rd_rise;
  logic wr_rise;

  assign idx = start_address_latch[5:0];
  // inputs are synchronous to mclk, so only one register stage
  assign latch_event = (als_q && !port.address_latch_strobe && !port.port_select_n)
    || (!sel_q && port.port_select_n && port.address_latch_strobe);
  assign rd_rise = !rd_q && !port.port_select_n && port.host_read_strobe_n == 1'b0
    && state == HIDP_DS_IDLE && !port.address_latch_strobe;
  assign wr_rise = !wr_q && !port.port_select_n && port.host_write_strobe_n == 1'b0
    && state == HIDP_DS_IDLE && !port.address_latch_strobe;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bus_q <= 16'h0000;
      sel_q <= 1'b0;
      als_q <= 1'b0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      bus_q <= port.shared_port_bus;
      sel_q <= port.port_select_n;
      als_q <= port.address_latch_strobe;
      rd_q <= !port.host_read_strobe_n;
      wr_q <= !port.host_write_strobe_n;
    end
  end

  // ----------------------------------------------------------------
  // control word: from the host latch or the processor register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      start_address_latch <= '0;
      mem_is_dm <= 1'b0;
      overlay_select <= 8'h00;
      half_sel <= 1'b0;
    end else if (cpu_write && cpu_addr == HIDP_CTRL_ADDR) begin
      if (cpu_wdata[HIDP_OVL_FLAG_BIT]) begin
        overlay_select <= cpu_wdata[HIDP_OVL_W-1:0];
      end else begin
        start_address_latch <= cpu_wdata[HIDP_ADDR_W-1:0];
        mem_is_dm <= cpu_wdata[HIDP_MEM_TYPE_BIT];
        half_sel <= 1'b0;
      end
    end else if (latch_event && state == HIDP_DS_IDLE) begin
      if (bus_q[HIDP_OVL_FLAG_BIT]) begin
        overlay_select <= bus_q[HIDP_OVL_W-1:0];
      end else begin
        start_address_latch <= bus_q[HIDP_ADDR_W-1:0];
        mem_is_dm <= bus_q[HIDP_MEM_TYPE_BIT];
        half_sel <= 1'b0;
      end
    end else if (state == HIDP_DS_MEM) begin
      if (mem_is_dm || half_sel) begin
        start_address_latch <= start_address_latch + 1'b1;
        half_sel <= 1'b0;
      end else begin
        half_sel <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= HIDP_DS_IDLE;
      op_write <= 1'b0;
    end else begin
      case (state)
        HIDP_DS_IDLE: begin
          if (rd_rise || wr_rise) begin
            op_write <= wr_rise;
            state <= HIDP_DS_SYNC;
          end
        end
        HIDP_DS_SYNC: begin
          state <= HIDP_DS_MEM;
        end
        HIDP_DS_MEM: begin
          state <= HIDP_DS_DONE;
        end
        HIDP_DS_DONE: begin
          if (port.host_read_strobe_n && port.host_write_strobe_n) begin
            state <= HIDP_DS_IDLE;
          end
        end
        default: begin
          state <= HIDP_DS_IDLE;
        end
      endcase
    end
  end

  // memories only; control registers never sit behind the port
  always_ff @(posedge mclk) begin
    if (state == HIDP_DS_MEM && op_write) begin
      if (mem_is_dm) begin
        data_memory[idx] <= bus_q;
      end else if (!half_sel) begin
        pm_low <= bus_q;
      end else begin
        program_memory[idx] <= {bus_q[7:0], pm_low};
      end
    end
  end

  // ----------------------------------------------------------------
  // port outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      port.bus_dev_out <= 16'h0000;
      port.bus_dev_oe <= 1'b0;
      port.port_ack <= 1'b0;
    end else begin
      port.port_ack <= (state == HIDP_DS_IDLE && !rd_rise && !wr_rise)
        || state == HIDP_DS_DONE;
      if (state == HIDP_DS_MEM && !op_write) begin
        if (mem_is_dm) begin
          port.bus_dev_out <= data_memory[idx];
        end else if (!half_sel) begin
          port.bus_dev_out <= program_memory[idx][15:0];
        end else begin
          port.bus_dev_out <= {8'h00, program_memory[idx][23:16]};
        end
      end
      // address latch is write only: bus driven only during reads
      port.bus_dev_oe <= !port.port_select_n && !port.host_read_strobe_n
        && (state == HIDP_DS_DONE);
    end
  end

  // ----------------------------------------------------------------
  // timing register, boot control, processor read-back
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      timing_reg <= HIDP_TIMING_RESET;
    end else if (cpu_write && cpu_addr == HIDP_TIMING_ADDR) begin
      timing_reg <= cpu_wdata;
    end
  end
  assign short_read_mode = timing_reg[HIDP_TIMING_SHORT_BIT];

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      strap_taken <= 1'b0;
      boot_port <= 1'b0;
      core_run <= 1'b0;
    end else begin
      if (!strap_taken) begin
        strap_taken <= 1'b1;
        boot_port <= (boot_mode == HIDP_BOOT_PORT_MODE);
        core_run <= (boot_mode != HIDP_BOOT_PORT_MODE);
      end else if (boot_port && state == HIDP_DS_MEM && op_write && !mem_is_dm
        && half_sel && start_address_latch == '0) begin
        core_run <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_rdata <= 16'h0000;
    end else if (cpu_read && cpu_addr == HIDP_CTRL_ADDR) begin
      cpu_rdata <= {2'b00, start_address_latch};
    end else if (cpu_read && cpu_addr == HIDP_TIMING_ADDR) begin
      cpu_rdata <= timing_reg;
    end else begin
      cpu_rdata <= 16'h0000;
    end
  end
endmodule : hidp_device

/* File: logic/hidp_host.sv */
`timescale 1ns/100ps
module hidp_host
  import hidp_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  // host port
  hidp_if.host port
);
  // ----------------------------------------------------------------
  // command buffer
  // ----------------------------------------------------------------
  hidp_hstate_t state;
  logic [1:0] cmd_op;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic cmd_valid;
  logic cmd_ready;
  logic [HIDP_CMD_W-1:0] cmd_data;
  logic fifo_in_ready;
  logic [1:0] cur_op;
  logic [15:0] cur_data;
  logic rdata_new;
  logic busy_seen;

  assign cmd_valid = reg_write && reg_addr == HIDP_HC_CMD;
  assign cmd_ready = (state == HIDP_HS_IDLE);

  hidp_fifo #(.WIDTH(HIDP_CMD_W), .DEPTH(HIDP_FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .in_valid(cmd_valid),
    .in_ready(fifo_in_ready),
    .in_data({reg_wdata[1:0], wdata}),
    .out_valid(),
    .out_ready(cmd_ready),
    .out_data(cmd_data)
  );

  logic fifo_has;
  hidp_fifo #(.WIDTH(1), .DEPTH(HIDP_FIFO_DEPTH)) u_tag (
    .mclk(mclk),
    .reset_n(reset_n),
    .in_valid(cmd_valid),
    .in_ready(),
    .in_data(1'b1),
    .out_valid(fifo_has),
    .out_ready(cmd_ready),
    .out_data()
  );

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wdata <= 16'h0000;
    end else if (reg_write && reg_addr == HIDP_HC_WDATA) begin
      wdata <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // pin sequencer: wait for ack, strobe, then for data transfers wait for ack again
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= HIDP_HS_IDLE;
      cur_op <= HIDP_OP_LATCH;
      cur_data <= 16'h0000;
      port.port_select_n <= 1'b1;
      port.address_latch_strobe <= 1'b0;
      port.host_read_strobe_n <= 1'b1;
      port.host_write_strobe_n <= 1'b1;
      port.bus_host_out <= 16'h0000;
      port.bus_host_oe <= 1'b0;
      rdata <= 16'h0000;
      rdata_new <= 1'b0;
      busy_seen <= 1'b0;
    end else begin
      case (state)
        HIDP_HS_IDLE: begin
          if (fifo_has) begin
            cur_op <= cmd_data[HIDP_CMD_W-1 -: 2];
            cur_data <= cmd_data[15:0];
            state <= HIDP_HS_WAITACK;
          end
        end
        HIDP_HS_WAITACK: begin
          if (port.port_ack) begin
            port.port_select_n <= 1'b0;
            if (cur_op == HIDP_OP_LATCH) begin
              port.address_latch_strobe <= 1'b1;
              port.bus_host_out <= cur_data[15] ? {8'h80, cur_data[7:0]} : cur_data;
              port.bus_host_oe <= 1'b1;
            end else if (cur_op == HIDP_OP_WRITE) begin
              port.host_write_strobe_n <= 1'b0;
              port.bus_host_out <= cur_data;
              port.bus_host_oe <= 1'b1;
            end else begin
              port.host_read_strobe_n <= 1'b0;
            end
            busy_seen <= 1'b0;
            state <= HIDP_HS_STROBE;
          end
        end
        HIDP_HS_STROBE: begin
          // latch needs a falling strobe; data needs the device to finish
          // ack still shows idle for a cycle after the strobe, so wait for busy first
          if (!port.port_ack) begin
            busy_seen <= 1'b1;
          end
          if (cur_op == HIDP_OP_LATCH) begin
            port.address_latch_strobe <= 1'b0;
            state <= HIDP_HS_END;
          end else if (busy_seen && port.port_ack
            && port.bus_host_oe == (cur_op == HIDP_OP_WRITE)) begin
            if (cur_op == HIDP_OP_READ) begin
              rdata <= port.shared_port_bus;
              rdata_new <= 1'b1;
            end
            port.host_read_strobe_n <= 1'b1;
            port.host_write_strobe_n <= 1'b1;
            state <= HIDP_HS_END;
          end
        end
        HIDP_HS_END: begin
          port.port_select_n <= 1'b1;
          port.bus_host_oe <= 1'b0;
          state <= HIDP_HS_IDLE;
        end
        default: begin
          state <= HIDP_HS_IDLE;
        end
      endcase
      if (reg_read && reg_addr == HIDP_HC_RDATA) begin
        rdata_new <= 1'b0;
      end
      if (state == HIDP_HS_STROBE && cur_op == HIDP_OP_READ && port.port_ack && busy_seen) begin
        rdata_new <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // register read-back
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_read && reg_addr == HIDP_HC_RDATA) begin
      reg_rdata <= rdata;
    end else if (reg_read && reg_addr == HIDP_HC_STATUS) begin
      reg_rdata <= {12'h000, rdata_new, fifo_in_ready, fifo_has, state == HIDP_HS_IDLE};
    end else if (reg_read && reg_addr == HIDP_HC_WDATA) begin
      reg_rdata <= wdata;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule : hidp_host

/* File: dv/hidp_props.sv */
`timescale 1ns/100ps
module hidp_props (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // host strobes
  input wire logic port_select_n,
  input wire logic address_latch_strobe,
  input wire logic host_read_strobe_n,
  input wire logic host_write_strobe_n,
  // device answer and bus drivers
  input wire logic port_ack,
  input wire logic bus_host_oe,
  input wire logic bus_dev_oe,
  input wire logic [15:0] shared_port_bus
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  // ----------------------------------------------------------------
  // transfer steps
  // ----------------------------------------------------------------
  sequence s_req;
    !port_select_n && ($fell(host_read_strobe_n) || $fell(host_write_strobe_n));
  endsequence
  // busy must clear again, or the host hangs waiting for it
  sequence s_busy;
    !port_ack ##[1:6] port_ack;
  endsequence
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_ack_before_strobe: assert property (s_req |-> $past(port_ack))
    else $error("data strobe raised while port busy");
  a_latch_waits_ack: assert property ($rose(address_latch_strobe) |-> $past(port_ack))
    else $error("address latch raised while port busy");
  a_latch_bus_valid: assert property ($fell(address_latch_strobe) |->
    $past(!port_select_n && bus_host_oe))
    else $error("address latch fell without select and driven bus");
  a_busy_per_word: assert property (s_req |-> ##[0:3] s_busy)
    else $error("access did not show one bounded busy period");
  a_strobe_excl: assert property (!(!host_read_strobe_n && !host_write_strobe_n))
    else $error("read and write strobes low together");
  a_strobe_select: assert property ((!host_read_strobe_n || !host_write_strobe_n) |->
    !port_select_n)
    else $error("data strobe without port select");
  a_no_contend: assert property (!(bus_host_oe && bus_dev_oe))
    else $error("both ends drive the shared bus");
  a_dev_drive_read: assert property (bus_dev_oe |->
    (!host_read_strobe_n || $past(!host_read_strobe_n)))
    else $error("device drives bus outside a read");
  a_write_data: assert property (!host_write_strobe_n |-> bus_host_oe)
    else $error("write strobe without host data");
  a_write_stable: assert property ((!host_write_strobe_n && $past(!host_write_strobe_n)) |->
    $stable(shared_port_bus))
    else $error("write data moved under the strobe");
endmodule : hidp_props

/* File: dv/host_internal_memory_dma_port_tb.sv */
`timescale 1ns/100ps
module host_internal_memory_dma_port_tb;
  import hidp_pkg::*;
  logic mclk;
  logic reset_n;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [15:0] reg_rdata;
  logic [13:0] cpu_addr;
  logic [15:0] cpu_wdata;
  logic cpu_write;
  logic cpu_read;
  logic [15:0] cpu_rdata;
  logic [2:0] boot_mode;
  logic core_run;
  logic [7:0] overlay_select;
  logic short_read_mode;
  int errors;
  int compares;
  int cycles;
  logic [15:0] v;
  // second word of each pair fits eight bits, so a program word pair reads back whole
  logic [15:0] wl [4] = '{16'h1111, 16'h0022, 16'h3333, 16'h0044};

  hidp_if hidp_if_inst ();
  hidp_host hidp_host_inst (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .port(hidp_if_inst));
  hidp_device hidp_device_inst (.mclk(mclk), .reset_n(reset_n), .port(hidp_if_inst),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_write(cpu_write),
    .cpu_read(cpu_read), .cpu_rdata(cpu_rdata), .boot_mode(boot_mode),
    .core_run(core_run), .overlay_select(overlay_select),
    .short_read_mode(short_read_mode));
  hidp_props hidp_props_inst (.mclk(mclk), .reset_n(reset_n),
    .port_select_n(hidp_if_inst.port_select_n),
    .address_latch_strobe(hidp_if_inst.address_latch_strobe),
    .host_read_strobe_n(hidp_if_inst.host_read_strobe_n),
    .host_write_strobe_n(hidp_if_inst.host_write_strobe_n),
    .port_ack(hidp_if_inst.port_ack), .bus_host_oe(hidp_if_inst.bus_host_oe),
    .bus_dev_oe(hidp_if_inst.bus_dev_oe), .shared_port_bus(hidp_if_inst.shared_port_bus));

  // ----------------------------------------------------------------
  // clock, timeout, report
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors = errors + 1;
      results();
    end
  end
  task results;
    if (errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("CHECK FAILED %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // ----------------------------------------------------------------
  // bus tasks, entered just after a rising edge
  // ----------------------------------------------------------------
  task hw(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
    @(posedge mclk);
  endtask : hw
  task hr(input logic [3:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    @(posedge mclk);
    d = reg_rdata;
  endtask : hr
  task cw(input logic [13:0] a, input logic [15:0] d);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_write <= 1'b1;
    @(posedge mclk);
    cpu_write <= 1'b0;
    @(posedge mclk);
  endtask : cw
  task cr(input logic [13:0] a, output logic [15:0] d);
    cpu_addr <= a;
    cpu_read <= 1'b1;
    @(posedge mclk);
    cpu_read <= 1'b0;
    @(posedge mclk);
    d = cpu_rdata;
  endtask : cr
  task cmd(input logic [1:0] op, input logic [15:0] d);
    hw(HIDP_HC_WDATA, d);
    hw(HIDP_HC_CMD, {14'h0000, op});
  endtask : cmd
  // idle twice in a row, so a queued command about to pop is not missed
  task wait_idle;
    int n;
    int ok;
    logic [15:0] s;
    n = 0;
    ok = 0;
    repeat (2) @(posedge mclk);
    while (ok < 2 && n < 200) begin
      hr(HIDP_HC_STATUS, s);
      n++;
      ok = (s[0] === 1'b1) ? ok + 1 : 0;
    end
    if (ok < 2) begin
      errors = errors + 1;
      $display("CHECK FAILED %0t: host controller never went idle", $time);
    end
  endtask : wait_idle
  task prd(output logic [15:0] d);
    cmd(HIDP_OP_READ, 16'h0000);
    wait_idle();
    hr(HIDP_HC_RDATA, d);
  endtask : prd
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset;
    cr(HIDP_CTRL_ADDR, v);
    chk(v, HIDP_CTRL_RESET);
    cr(HIDP_TIMING_ADDR, v);
    chk(v, HIDP_TIMING_RESET);
    chk({15'h0000, core_run}, 16'h0000);
    chk({8'h00, overlay_select}, 16'h0000);
  endtask : t_reset
  task t_boot;
    int t;
    for (t = 0; t < 2; t++) begin
      cmd(HIDP_OP_LATCH, {1'b0, t[0], 14'h0000});
      cmd(HIDP_OP_WRITE, 16'h1234);
      wait_idle();
      if (t == 0) begin
        chk({15'h0000, core_run}, 16'h0000);
      end
      cmd(HIDP_OP_WRITE, 16'h005A);
      wait_idle();
    end
    chk({15'h0000, core_run}, 16'h0001);
    for (t = 0; t < 2; t++) begin
      cmd(HIDP_OP_LATCH, {1'b0, t[0], 14'h0000});
      prd(v);
      chk(v, 16'h1234);
      prd(v);
      chk(v, 16'h005A);
    end
  endtask : t_boot
  task t_overlay;
    cmd(HIDP_OP_LATCH, 16'h80C3);
    wait_idle();
    chk({8'h00, overlay_select}, 16'h00C3);
    cr(HIDP_CTRL_ADDR, v);
    chk(v, 16'h0002);
    cmd(HIDP_OP_LATCH, 16'h0005);
    wait_idle();
    chk({8'h00, overlay_select}, 16'h00C3);
    cr(HIDP_CTRL_ADDR, v);
    chk(v, 16'h0005);
  endtask : t_overlay
  task t_seq;
    int t;
    int i;
    for (t = 0; t < 2; t++) begin
      // commands queue in the buffer while the port is still busy
      cmd(HIDP_OP_LATCH, {1'b0, t[0], 14'h0008});
      for (i = 0; i < 4; i++) begin
        cmd(HIDP_OP_WRITE, wl[i]);
      end
      wait_idle();
      cmd(HIDP_OP_LATCH, {1'b0, t[0], 14'h0008});
      for (i = 0; i < 4; i++) begin
        prd(v);
        chk(v, wl[i]);
      end
    end
  endtask : t_seq
  task t_cpu;
    int t;
    cw(HIDP_TIMING_ADDR, 16'h4000);
    chk({15'h0000, short_read_mode}, 16'h0001);
    cr(HIDP_TIMING_ADDR, v);
    chk(v, 16'h4000);
    cw(HIDP_CTRL_ADDR, 16'h0008);
    prd(v);
    chk(v, wl[0]);
    for (t = 0; t < 2; t++) begin
      cmd(HIDP_OP_LATCH, {1'b0, t[0], HIDP_TIMING_ADDR});
      cmd(HIDP_OP_WRITE, 16'hFFFF);
      cmd(HIDP_OP_WRITE, 16'h00FF);
      wait_idle();
      cr(HIDP_TIMING_ADDR, v);
      chk(v, 16'h4000);
    end
  endtask : t_cpu
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    compares = 0;
    cycles = 0;
    reset_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    cpu_addr = 14'h0000;
    cpu_wdata = 16'h0000;
    cpu_write = 1'b0;
    cpu_read = 1'b0;
    boot_mode = HIDP_BOOT_PORT_MODE;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (2) @(posedge mclk);
    t_reset();
    t_boot();
    t_overlay();
    t_seq();
    t_cpu();
    results();
  end
endmodule : host_internal_memory_dma_port_tb
